// ### rtl/fcd_pkg.sv
// Shared constants for the flash command decoder.
package fcd_pkg;
  // Register byte offsets on the APB.
  localparam logic [7:0] FCD_CMD_OFF = 8'h00; // Command cycle.
  localparam logic [7:0] FCD_ARG_OFF = 8'h04; // Argument cycle.
  localparam logic [7:0] FCD_STAT_OFF = 8'h08; // Status, direct view.
  localparam logic [7:0] FCD_RDAT_OFF = 8'h0C; // Mode-steered read port.
  localparam logic [7:0] FCD_RADR_OFF = 8'h10; // Read address.
  // Command codes.
  localparam logic [7:0] FCD_C_RDARR = 8'hFF;
  localparam logic [7:0] FCD_C_PROG = 8'h80;
  localparam logic [7:0] FCD_C_PERASE = 8'h40;
  localparam logic [7:0] FCD_C_MERASE = 8'h20;
  localparam logic [7:0] FCD_C_RDSTAT = 8'h10;
  localparam logic [7:0] FCD_C_CLRST = 8'hA0;
  localparam logic [7:0] FCD_C_MAIN = 8'hB0;
  localparam logic [7:0] FCD_C_INFO = 8'hC0;
  // Status bit positions.
  localparam int FCD_S_BUSY = 7;
  localparam int FCD_S_CMDERR = 6;
  localparam int FCD_S_PROTERR = 5;
  localparam int FCD_S_SETUPERR = 4;
  localparam int FCD_S_INFO = 3;
  localparam int FCD_S_LOCK = 2;
  // Argument word layout: address in 23:8, data in 7:0.
  localparam int FCD_ARG_ADR_LSB = 8;
  localparam int FCD_ARG_ADR_MSB = 23;
  // Boot block is the lowest 2K bytes of the main block.
  localparam logic [15:0] FCD_BOOT_END = 16'h0800;
  // Page number is address bits 15:9.
  localparam int FCD_PAGE_LSB = 9;
  // Operation codes driven to the array.
  localparam logic [1:0] FCD_OP_NONE = 2'h0;
  localparam logic [1:0] FCD_OP_PROG = 2'h1;
  localparam logic [1:0] FCD_OP_PERASE = 2'h2;
  localparam logic [1:0] FCD_OP_MERASE = 2'h3;
  // Sequencer states.
  typedef enum logic [1:0] {
    FCD_ST_IDLE = 2'b00,
    FCD_ST_WPROG = 2'b01,
    FCD_ST_WERASE = 2'b10
  } fcd_state_t;
endpackage : fcd_pkg

// ### rtl/fcd_flash_command_decoder.sv
`timescale 1ns/1ps
// Function
// - FF selects array-read output mode.
// - Reset comes up in array-read mode.
// - 80 latches address and byte argument.
// - Program argument starts programming, status mode.
// - Protected boot byte program is refused.
// - 40 latches page address argument.
// - Erase argument starts page erase, status mode.
// - Protected boot page erase is refused.
// - 20 starts mass erase, status mode.
// - Info selected: mass erase clears both.
// - Main selected: mass erase main only.
// - Mass erase inhibited while boot locked.
// - 10 selects status read, no operation.
// - Every non-FF command enters status mode.
// - A0 clears error flags, status mode.
// - B0 selects main block, status mode.
// - Main selection persists until info select.
// - C0 selects info block until B0.
// - Reserved codes set command error, status mode.
// - Command or argument writes while busy set command error.
// - Missing argument cycle sets setup error.
// - Busy rises at argument or mass erase.
// - Protected requests set protection error.
module fcd_flash_command_decoder
  import fcd_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boot_write_protect_n,
  input wire logic [DATA_W-1:0] flash_rdata,
  input wire logic flash_done,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] program_write_byte,
  output logic [1:0] flash_op,
  output logic flash_start,
  output logic flash_info_sel,
  output logic flash_erase_info,
  output logic status_mode
);

  // Write-protect pin passes two flops before use.
  // Both flops reset to the unlocked level, so a lock is seen two edges late.
  logic wp_meta_r;
  logic wp_sync_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_meta_r <= 1'b1;
      wp_sync_r <= 1'b1;
    end else begin
      wp_meta_r <= boot_write_protect_n;
      wp_sync_r <= wp_meta_r;
    end
  end
  // Active-high lock, from the synchronised pin.
  wire locked = !wp_sync_r;

  // Sequencer and status state.
  fcd_state_t state_r; // Waiting for an argument or idle.
  fcd_state_t state_nxt;
  logic busy_r; // Program or erase in progress.
  logic busy_nxt;
  logic cmd_err_r; // Reserved code, argument with no command, or write while busy.
  logic cmd_err_nxt;
  logic prot_err_r; // Request hit protected memory.
  logic prot_err_nxt;
  logic setup_err_r; // Argument cycle missing.
  logic setup_err_nxt;
  logic info_r; // Information block selected.
  logic info_nxt;
  logic stmode_r; // Read port returns status.
  logic stmode_nxt;
  logic [ADDR_W-1:0] tgt_r; // Latched target address.
  logic [ADDR_W-1:0] tgt_nxt;
  logic [DATA_W-1:0] wbyte_r; // Latched program byte.
  logic [DATA_W-1:0] wbyte_nxt;
  logic [1:0] op_r; // Operation handed to the array.
  logic [1:0] op_nxt;
  logic start_r; // One-cycle start pulse.
  logic start_nxt;
  logic both_r; // Mass erase includes info block.
  logic both_nxt;
  logic [ADDR_W-1:0] radr_r; // Address for array reads.
  logic [ADDR_W-1:0] radr_nxt; // Read address after this edge.
  logic [31:0] prdata_r; // Read word captured in the setup phase.
  logic [ADDR_W-1:0] faddr_r; // Address presented to the array.

  // Bus decode: pready is always high, so access is one cycle.
  // Writes to read-only or unmapped offsets change no state.
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_cmd = (paddr == FCD_CMD_OFF);
  wire hit_arg = (paddr == FCD_ARG_OFF);
  wire hit_stat = (paddr == FCD_STAT_OFF);
  wire hit_rdat = (paddr == FCD_RDAT_OFF);
  wire hit_radr = (paddr == FCD_RADR_OFF);
  wire mapped = hit_cmd || hit_arg || hit_stat || hit_rdat || hit_radr;
  wire cmd_wr = wr && hit_cmd;
  wire arg_wr = wr && hit_arg;
  wire [7:0] code = pwdata[7:0];
  // Argument word: address field above the data byte.
  wire [ADDR_W-1:0] arg_adr =
    ADDR_W'(pwdata[FCD_ARG_ADR_MSB:FCD_ARG_ADR_LSB]);
  wire [DATA_W-1:0] arg_dat = pwdata[DATA_W-1:0];

  // Only main-block addresses below the boot limit are protected; the
  // information block has no boot region.
  wire in_boot = !info_r && (arg_adr < FCD_BOOT_END);
  wire arg_prot = locked && in_boot;

  // Status byte as software sees it.
  logic [7:0] status;
  always_comb begin
    // Reserved low bits read as zero.
    status = 8'h00;
    status[FCD_S_BUSY] = busy_r;
    status[FCD_S_CMDERR] = cmd_err_r;
    status[FCD_S_PROTERR] = prot_err_r;
    status[FCD_S_SETUPERR] = setup_err_r;
    status[FCD_S_INFO] = info_r;
    status[FCD_S_LOCK] = locked;
  end

  // Read port follows the output mode: status or array data.
  wire [7:0] rport = stmode_r ? status : 8'(flash_rdata);
  wire [31:0] rd_mux = hit_stat ? {24'h00_0000, status} :
                       hit_rdat ? {24'h00_0000, rport} :
                       hit_radr ? 32'(radr_r) : 32'h0000_0000;
  // The read word is taken at the setup edge, so prdata comes from a flop
  // and still needs no wait state.  The price is that it shows the state
  // of one cycle before the access edge, so busy may read a cycle stale.
  wire rd_setup = psel && !penable && !pwrite;
  wire [31:0] prdata_nxt = rd_setup ? rd_mux : 32'h0000_0000;
  assign prdata = prdata_r;
  // Zero wait states: every access ends in its first access cycle.
  assign pready = 1'b1;
  // Unmapped offsets answer with an error and change nothing.
  assign pslverr = acc && !mapped;

  // Command sequencer.
  always_comb begin
    // Everything but the start pulse holds unless a branch below moves it.
    state_nxt = state_r;
    busy_nxt = busy_r;
    cmd_err_nxt = cmd_err_r;
    prot_err_nxt = prot_err_r;
    setup_err_nxt = setup_err_r;
    info_nxt = info_r;
    stmode_nxt = stmode_r;
    tgt_nxt = tgt_r;
    wbyte_nxt = wbyte_r;
    op_nxt = op_r;
    start_nxt = 1'b0;
    both_nxt = both_r;
    // The array's completion ends busy.
    if (busy_r && flash_done) begin
      busy_nxt = 1'b0;
      op_nxt = FCD_OP_NONE;
    end
    if ((cmd_wr || arg_wr) && busy_r) begin
      // Busy writes are dropped but flagged.
      cmd_err_nxt = 1'b1;
      stmode_nxt = 1'b1;
    end else if (arg_wr) begin
      stmode_nxt = 1'b1;
      state_nxt = FCD_ST_IDLE;
      unique case (state_r)
        // Program: latch both fields, then start unless protected.
        FCD_ST_WPROG: begin
          tgt_nxt = arg_adr;
          wbyte_nxt = arg_dat;
          if (arg_prot) begin
            prot_err_nxt = 1'b1;
          end else begin
            busy_nxt = 1'b1;
            start_nxt = 1'b1;
            op_nxt = FCD_OP_PROG;
          end
        end
        // Page erase: the data byte of the argument is ignored.
        FCD_ST_WERASE: begin
          tgt_nxt = arg_adr;
          if (arg_prot) begin
            prot_err_nxt = 1'b1;
          end else begin
            busy_nxt = 1'b1;
            start_nxt = 1'b1;
            op_nxt = FCD_OP_PERASE;
          end
        end
        default: begin
          // An argument with no command before it is a bad command.
          cmd_err_nxt = 1'b1;
        end
      endcase
    end else if (cmd_wr) begin
      state_nxt = FCD_ST_IDLE;
      stmode_nxt = 1'b1;
      unique case (code)
        // Array-read is the one code that leaves status mode.
        FCD_C_RDARR: begin
          stmode_nxt = 1'b0;
        end
        // Two-cycle commands only arm the argument cycle here.
        FCD_C_PROG: begin
          state_nxt = FCD_ST_WPROG;
        end
        FCD_C_PERASE: begin
          state_nxt = FCD_ST_WERASE;
        end
        // Mass erase starts on this write; a lock refuses all of it.
        FCD_C_MERASE: begin
          if (locked) begin
            prot_err_nxt = 1'b1;
          end else begin
            busy_nxt = 1'b1;
            start_nxt = 1'b1;
            op_nxt = FCD_OP_MERASE;
            // The block selection decides whether info goes too.
            both_nxt = info_r;
          end
        end
        // Status read changes nothing beyond the output mode.
        FCD_C_RDSTAT: begin
          stmode_nxt = 1'b1;
        end
        FCD_C_CLRST: begin
          // Busy is left alone; only error flags clear.
          cmd_err_nxt = 1'b0;
          prot_err_nxt = 1'b0;
          setup_err_nxt = 1'b0;
        end
        // Block selection persists until the other select arrives.
        FCD_C_MAIN: begin
          info_nxt = 1'b0;
        end
        FCD_C_INFO: begin
          info_nxt = 1'b1;
        end
        // Reserved codes flag the error and select status mode.
        default: begin
          cmd_err_nxt = 1'b1;
        end
      endcase
      // A command where an argument was due aborts the pending one, yet
      // the new code is still decoded so that software is not stalled.
      // The flag is raised after the decode, so a clear-status written in
      // place of the argument cannot wipe the error that it causes itself.
      if (state_r != FCD_ST_IDLE) begin
        setup_err_nxt = 1'b1;
      end
    end
  end

  // Sequencer registers; reset gives array-read on the main block.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= FCD_ST_IDLE;
      busy_r <= 1'b0;
      cmd_err_r <= 1'b0;
      prot_err_r <= 1'b0;
      setup_err_r <= 1'b0;
      // Errors and busy clear; the output mode comes up as array read.
      info_r <= 1'b0;
      stmode_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= busy_nxt;
      cmd_err_r <= cmd_err_nxt;
      prot_err_r <= prot_err_nxt;
      setup_err_r <= setup_err_nxt;
      info_r <= info_nxt;
      stmode_r <= stmode_nxt;
    end
  end

  // Argument latches and array command outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_r <= '0;
      wbyte_r <= '0;
      // No operation is handed to the array after reset.
      op_r <= FCD_OP_NONE;
      start_r <= 1'b0;
      both_r <= 1'b0;
    end else begin
      tgt_r <= tgt_nxt;
      wbyte_r <= wbyte_nxt;
      op_r <= op_nxt;
      start_r <= start_nxt;
      both_r <= both_nxt;
    end
  end

  // Read address register, writable at any time, even while busy.
  assign radr_nxt = (wr && hit_radr) ? arg_adr : radr_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      radr_r <= '0;
    end else begin
      radr_r <= radr_nxt;
    end
  end

  // The array address is registered from next-state values, so it moves
  // on the same edge as a mux of busy, target and read address would.
  wire [ADDR_W-1:0] faddr_nxt = busy_nxt ? tgt_nxt : radr_nxt;
  // Registered bus read data and array address.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      faddr_r <= '0;
    end else begin
      prdata_r <= prdata_nxt;
      faddr_r <= faddr_nxt;
    end
  end

  // While an operation runs the array sees its target; otherwise the
  // read address, so array reads need a separate bus read.
  assign flash_addr = faddr_r;
  assign program_write_byte = wbyte_r;
  assign flash_op = op_r;
  assign flash_start = start_r;
  assign flash_info_sel = info_r;
  assign flash_erase_info = both_r;
  assign status_mode = stmode_r;

endmodule : fcd_flash_command_decoder

// ### bench/fcd_flash_model.sv
`timescale 1ns/1ps
// Behavioural flash array that answers the sequencer, prompt or slow.
module fcd_flash_model
  import fcd_pkg::*;
(
  input wire logic pclk,
  input wire logic slow,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] program_write_byte,
  input wire logic [1:0] flash_op,
  input wire logic flash_start,
  output logic [7:0] flash_rdata,
  output logic flash_done
);
  logic [7:0] mem [0:65535]; // Main block contents.
  int cnt = 0; // Cycles left in the running operation.
  // Reads are combinational, like the real array.
  assign flash_rdata = mem[flash_addr];
  initial begin
    flash_done = 1'b0;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // An operation ends with a one-cycle done pulse.
  always @(posedge pclk) begin
    flash_done <= (cnt == 1);
    if (flash_start) cnt <= slow ? 40 : 2;
    else if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 1) begin
      case (flash_op)
        FCD_OP_PROG: mem[flash_addr] <= mem[flash_addr] & program_write_byte;
        FCD_OP_PERASE: for (int i = 0; i < 512; i++)
          mem[{flash_addr[15:9], i[8:0]}] <= 8'hFF;
        FCD_OP_MERASE: foreach (mem[i]) mem[i] <= 8'hFF;
        default: ;
      endcase
    end
  end
endmodule : fcd_flash_model

// ### bench/fcd_flash_command_decoder_assertions.sv
`timescale 1ns/1ps
// Port-level checks of the command sequencer.
module fcd_flash_command_decoder_assertions
  import fcd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic boot_write_protect_n,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_done,
  input wire logic [1:0] flash_op,
  input wire logic flash_start,
  input wire logic flash_info_sel,
  input wire logic flash_erase_info,
  input wire logic status_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cw; // A command write is taken.
  logic idle; // No operation is running.
  logic [7:0] c; // Code of the write.
  assign cw = psel && penable && pwrite && paddr == FCD_CMD_OFF;
  assign idle = flash_op == FCD_OP_NONE;
  assign c = pwdata[7:0];
  property p_rdarr;
    cw && idle && c == FCD_C_RDARR |=> !status_mode;
  endproperty
  a_rdarr: assert property (p_rdarr) else $error("no array mode");
  property p_stmode;
    cw && c != FCD_C_RDARR |=> status_mode;
  endproperty
  a_stmode: assert property (p_stmode) else $error("no status mode");
  property p_merase;
    cw && idle && c == FCD_C_MERASE && $past(boot_write_protect_n) &&
      $past(boot_write_protect_n, 2) && $past(boot_write_protect_n, 3)
      |=> flash_start && flash_op == FCD_OP_MERASE;
  endproperty
  a_merase: assert property (p_merase) else $error("no mass erase");
  property p_lock;
    cw && c == FCD_C_MERASE && !$past(boot_write_protect_n) &&
      !$past(boot_write_protect_n, 2) |=> !flash_start;
  endproperty
  a_lock: assert property (p_lock) else $error("locked erase");
  property p_einfo;
    flash_start && flash_op == FCD_OP_MERASE |->
      flash_erase_info == flash_info_sel;
  endproperty
  a_einfo: assert property (p_einfo) else $error("erase scope");
  property p_start;
    flash_start |-> !idle && status_mode ##1 !flash_start;
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_busyw;
    cw && !idle && !flash_done |=> !flash_start && flash_op == $past(flash_op);
  endproperty
  a_busyw: assert property (p_busyw) else $error("busy write acted");
  property p_sel;
    cw && idle && (c == FCD_C_INFO || c == FCD_C_MAIN) |=>
      flash_info_sel == ($past(c) == FCD_C_INFO);
  endproperty
  a_sel: assert property (p_sel) else $error("block select");
  property p_hold;
    $changed(flash_info_sel) |-> $past(cw);
  endproperty
  a_hold: assert property (p_hold) else $error("select moved");
  property p_rdat;
    psel && penable && !pwrite && paddr == FCD_RDAT_OFF && !status_mode
      |-> prdata[7:0] == flash_rdata;
  endproperty
  a_rdat: assert property (p_rdat) else $error("array data");
endmodule : fcd_flash_command_decoder_assertions

// ### bench/tb_flash_command_decoder.sv
`timescale 1ns/1ps
// Self-checking bench: APB master, flash model, queue-based read checker.
module tb_flash_command_decoder
  import fcd_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, flash_rdata, program_write_byte;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, flash_done, flash_start, flash_info_sel;
  logic boot_write_protect_n = 1, slow = 1, flash_erase_info, status_mode;
  logic [15:0] flash_addr, a;
  logic [1:0] flash_op;
  logic [7:0] d, rc;
  logic [7:0] ops [3] = '{FCD_C_PROG, FCD_C_PERASE, FCD_C_MERASE};
  logic [32:0] eq[$], mq[$]; // Expected read results and their masks.
  int failures = 0, n_compared = 0, cyc = 0;
  fcd_flash_command_decoder fcd_flash_command_decoder_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .boot_write_protect_n, .flash_rdata, .flash_done, .flash_addr,
    .program_write_byte, .flash_op, .flash_start, .flash_info_sel,
    .flash_erase_info, .status_mode);
  fcd_flash_model fcd_flash_model_inst (.pclk, .slow, .flash_addr,
    .program_write_byte, .flash_op, .flash_start, .flash_rdata, .flash_done);
  initial forever #12.5 pclk = ~pclk;
  task automatic print_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  // One APB transfer, held until pready is seen, then one idle cycle.
  task automatic ap(input logic w, input logic [7:0] ad,
    input logic [31:0] wd);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : ap
  task automatic rd(input logic [7:0] ad, input logic [32:0] e,
    input logic [31:0] m);
    eq.push_back(e); mq.push_back({1'b1, m}); ap(0, ad, 32'h0);
  endtask : rd
  task automatic cmd(input logic [7:0] cc); ap(1, FCD_CMD_OFF, {24'h0, cc});
  endtask : cmd
  task automatic st(input int b, input logic v); // One status bit.
    rd(FCD_STAT_OFF, 33'(v) << b, 32'(1) << b);
  endtask : st
  task automatic wt; // Waits, bounded, for the operation to end.
    for (int k = 0; k < 200 && flash_op !== FCD_OP_NONE; k++) @(posedge pclk);
    if (flash_op !== FCD_OP_NONE) begin failures++; print_verdict; end
  endtask : wt
  // Compares each read as it completes against the oldest note.
  always @(posedge pclk) begin : mon
    logic [32:0] e, m;
    if (psel && penable && !pwrite && eq.size() > 0) begin
      e = eq.pop_front(); m = mq.pop_front(); n_compared++;
      if ((({pslverr, prdata} ^ e) & m) !== 33'h0) begin
        failures++;
        $display("Error at %0t got %h expected %h", $time,
          {pslverr, prdata} & m, e);
      end
    end
  end
  // A hang is cut short well beyond the expected run length.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin failures++; print_verdict; end
  end
  initial begin
    void'($urandom(32'hb7c2));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    a = {1'b1, 15'($urandom)}; d = 8'($urandom);
    st(FCD_S_BUSY, 0); st(FCD_S_INFO, 0);
    ap(1, FCD_RADR_OFF, {8'h0, a, 8'h0});
    rd(FCD_RDAT_OFF, 33'hFF, 32'hFF);
    rd(8'h14, 33'h1_0000_0000, 32'h0);
    $display("test 1 done");
    cmd(FCD_C_PROG); ap(1, FCD_ARG_OFF, {8'h0, a, d});
    rd(FCD_RDAT_OFF, 33'h80, 32'h80);
    wt; cmd(FCD_C_RDARR); rd(FCD_RDAT_OFF, {25'h0, d}, 32'hFF);
    slow <= 0;
    cmd(FCD_C_PERASE); ap(1, FCD_ARG_OFF, {8'h0, a, 8'h0}); wt;
    cmd(FCD_C_RDARR); rd(FCD_RDAT_OFF, 33'hFF, 32'hFF);
    $display("test 2 done");
    slow <= 1; boot_write_protect_n <= 0;
    repeat (3) @(posedge pclk);
    for (int k = 0; k < 3; k++) begin
      cmd(ops[k]);
      if (k < 2) ap(1, FCD_ARG_OFF, {8'h0, 16'h07FF, 8'h0});
      st(FCD_S_PROTERR, 1); st(FCD_S_BUSY, 0);
      cmd(FCD_C_CLRST); st(FCD_S_PROTERR, 0);
    end
    boot_write_protect_n <= 1;
    repeat (3) @(posedge pclk);
    $display("test 3 done");
    cmd(FCD_C_INFO); st(FCD_S_INFO, 1);
    cmd(FCD_C_MERASE); st(FCD_S_BUSY, 1);
    cmd(FCD_C_RDSTAT); st(FCD_S_CMDERR, 1); wt;
    cmd(FCD_C_CLRST); cmd(FCD_C_MAIN); st(FCD_S_INFO, 0);
    cmd(FCD_C_MERASE); wt; st(FCD_S_INFO, 0);
    $display("test 4 done");
    repeat (4) begin
      rc = 8'($urandom);
      if (rc inside {8'hFF, 8'h80, 8'h40, 8'h20, 8'h10, 8'hA0, 8'hB0, 8'hC0})
        rc = 8'h01;
      cmd(rc); st(FCD_S_CMDERR, 1); st(FCD_S_BUSY, 0);
      cmd(FCD_C_CLRST); st(FCD_S_CMDERR, 0);
    end
    cmd(FCD_C_RDARR); cmd(FCD_C_RDSTAT);
    rd(FCD_RDAT_OFF, 33'h0, 32'hF0);
    cmd(FCD_C_PROG); cmd(FCD_C_RDSTAT); st(FCD_S_SETUPERR, 1);
    $display("test 5 done");
    cmd(FCD_C_INFO); presetn <= 0; // Mid-run reset from status mode.
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    st(FCD_S_SETUPERR, 0); st(FCD_S_INFO, 0);
    rd(FCD_RDAT_OFF, 33'hFF, 32'hFF);
    $display("test 6 done");
    print_verdict;
  end
endmodule : tb_flash_command_decoder
bind fcd_flash_command_decoder fcd_flash_command_decoder_assertions chk_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .boot_write_protect_n, .flash_rdata, .flash_done, .flash_op, .flash_start,
  .flash_info_sel, .flash_erase_info, .status_mode);
